// ==== src/dpic_defines.vh ====
`ifndef DPIC_DEFINES_VH
`define DPIC_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DPIC_ADDR_DATAPATH 8'h1b
`define DPIC_ADDR_HB1 8'h1c
`define DPIC_ADDR_HB2 8'h1d
// ----------------------------------------
// datapath_control field positions
// ----------------------------------------
`define DPIC_BIT_PREMOD_SKIP 7
`define DPIC_BIT_SINC_SKIP 6
`define DPIC_BIT_OSC_SKIP 5
`define DPIC_BIT_OSC_HALF 3
`define DPIC_BIT_PHASE_SKIP 2
`define DPIC_BIT_SIDEBAND 1
`define DPIC_BIT_DUPLICATE 0
// ----------------------------------------
// half-band control field positions
// ----------------------------------------
`define DPIC_BIT_STAGE_SKIP 0
`define DPIC_HB1_MODE_MSB 2
`define DPIC_HB2_MODE_MSB 6
`define DPIC_MODE_LSB 1
// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define DPIC_DATAPATH_RST 8'he4
`define DPIC_DATAPATH_MASK 8'hef
`define DPIC_HB1_RST 8'h00
`define DPIC_HB1_MASK 8'h07
`define DPIC_HB2_RST 8'h00
`define DPIC_HB2_MASK 8'h7f
// ----------------------------------------
// arithmetic constants
// ----------------------------------------
`define DPIC_ROOT_HALF 10'sh0b5
`endif

// ==== src/dpic_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "dpic_defines.vh"

module dpic_top #(
    parameter [2:0] NCO_STEP = 3'h2,
    parameter signed [19:0] DC_I = 20'sh00000,
    parameter signed [19:0] DC_Q = 20'sh00000,
    parameter signed [7:0] PHASE_COEF = 8'sh00
) (
    input wire CLK_SYS_I, // 25 MHz system clock
    input wire RST_N_I, // async reset, active low
    input wire [7:0] REG_ADDR_I, // register address
    input wire [7:0] REG_WDATA_I, // register write data
    input wire REG_WR_I, // write strobe
    input wire REG_RD_I, // read strobe
    output reg [7:0] REG_RDATA_O, // registered read data
    input wire [15:0] IN_I_I, // I sample in
    input wire [15:0] IN_Q_I, // Q sample in
    input wire IN_VALID_I, // input sample valid
    output reg IN_READY_O, // buffer can take a sample
    output reg [15:0] OUT_I_O, // I converter sample
    output reg [15:0] OUT_Q_O, // Q converter sample
    output reg OUT_VALID_O, // output sample valid
    input wire OUT_READY_I // converter takes sample
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // multiply by one over root two
    function signed [19:0] root_half;
        input signed [19:0] x;
        reg signed [29:0] p;
        begin
            p = x * `DPIC_ROOT_HALF;
            root_half = p[27:8];
        end
    endfunction

    // rotate (i,q) by ang eighths of a turn, return i or q
    function signed [19:0] rot_sel;
        input signed [19:0] i;
        input signed [19:0] q;
        input [2:0] ang;
        input pick_q;
        reg signed [19:0] bi;
        reg signed [19:0] bq;
        reg signed [19:0] oi;
        reg signed [19:0] oq;
        begin
            bi = ang[0] ? root_half(i - q) : i;
            bq = ang[0] ? root_half(i + q) : q;
            case (ang[2:1])
                2'h0:
                begin
                    oi = bi;
                    oq = bq;
                end
                2'h1:
                begin
                    oi = -bq;
                    oq = bi;
                end
                2'h2:
                begin
                    oi = -bi;
                    oq = -bq;
                end
                default:
                begin
                    oi = bq;
                    oq = -bi;
                end
            endcase
            rot_sel = pick_q ? oq : oi;
        end
    endfunction

    // midpoint of two samples, the interpolated half-rate point
    function signed [19:0] avg2;
        input signed [19:0] a;
        input signed [19:0] b;
        reg signed [20:0] s;
        begin
            s = {a[19], a} + {b[19], b};
            avg2 = s[20:1];
        end
    endfunction

    // clip to the converter's 16 bits
    function [15:0] sat16;
        input signed [19:0] v;
        begin
            if (v[19:15] == 5'h00 || v[19:15] == 5'h1f)
                sat16 = v[15:0];
            else
                sat16 = v[19] ? 16'h8000 : 16'h7fff;
        end
    endfunction

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    reg [7:0] datapath_control;
    reg [7:0] first_halfband_control;
    reg [7:0] second_halfband_control;

    wire premod_skip = datapath_control[`DPIC_BIT_PREMOD_SKIP];
    wire sinc_skip = datapath_control[`DPIC_BIT_SINC_SKIP];
    wire oscillator_skip = datapath_control[`DPIC_BIT_OSC_SKIP];
    wire oscillator_half_gain = datapath_control[`DPIC_BIT_OSC_HALF];
    wire phase_skip = datapath_control[`DPIC_BIT_PHASE_SKIP];
    wire sideband_low = datapath_control[`DPIC_BIT_SIDEBAND];
    wire i_channel_duplicate = datapath_control[`DPIC_BIT_DUPLICATE];
    wire first_stage_skip = first_halfband_control[`DPIC_BIT_STAGE_SKIP];
    wire second_stage_skip = second_halfband_control[`DPIC_BIT_STAGE_SKIP];
    wire [1:0] first_halfband_mode =
        first_halfband_control[`DPIC_HB1_MODE_MSB:`DPIC_MODE_LSB];
    wire [5:0] second_halfband_mode =
        second_halfband_control[`DPIC_HB2_MODE_MSB:`DPIC_MODE_LSB];

    // writes masked so undescribed bits stay zero
    always @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            datapath_control <= `DPIC_DATAPATH_RST;
            first_halfband_control <= `DPIC_HB1_RST;
            second_halfband_control <= `DPIC_HB2_RST;
        end
        else if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                `DPIC_ADDR_DATAPATH:
                    datapath_control <= REG_WDATA_I & `DPIC_DATAPATH_MASK;
                `DPIC_ADDR_HB1:
                    first_halfband_control <= REG_WDATA_I & `DPIC_HB1_MASK;
                `DPIC_ADDR_HB2:
                    second_halfband_control <= REG_WDATA_I & `DPIC_HB2_MASK;
                default:
                    ;
            endcase
        end
    end

    // read data, unmapped addresses answer zero
    always @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            REG_RDATA_O <= 8'h00;
        else if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                `DPIC_ADDR_DATAPATH: REG_RDATA_O <= datapath_control;
                `DPIC_ADDR_HB1: REG_RDATA_O <= first_halfband_control;
                `DPIC_ADDR_HB2: REG_RDATA_O <= second_halfband_control;
                default: REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // two-entry input buffer
    // ----------------------------------------
    reg [15:0] buf_i [0:1];
    reg [15:0] buf_q [0:1];
    reg buf_wptr;
    reg buf_rptr;
    reg [1:0] buf_count;
    reg busy;
    wire buf_valid = (buf_count != 2'h0);
    wire push = IN_VALID_I & IN_READY_O;
    wire pop = buf_valid & ~busy;
    reg [1:0] next_count;

    always @*
    begin
        next_count = buf_count;
        if (push & ~pop)
            next_count = buf_count + 2'h1;
        else if (pop & ~push)
            next_count = buf_count - 2'h1;
    end

    // ready is registered, so it looks one cycle ahead via next_count
    always @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            buf_wptr <= 1'b0;
            buf_rptr <= 1'b0;
            buf_count <= 2'h0;
            IN_READY_O <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                buf_i[buf_wptr] <= IN_I_I;
                buf_q[buf_wptr] <= IN_Q_I;
                buf_wptr <= ~buf_wptr;
            end
            if (pop)
                buf_rptr <= ~buf_rptr;
            buf_count <= next_count;
            IN_READY_O <= (next_count != 2'h2);
        end
    end

    // ----------------------------------------
    // interpolation engine state
    // ----------------------------------------
    reg signed [19:0] x_i;
    reg signed [19:0] x_q;
    reg signed [19:0] x1p_i;
    reg signed [19:0] x1p_q;
    reg signed [19:0] y2p_i;
    reg signed [19:0] y2p_q;
    reg signed [19:0] s1_i;
    reg signed [19:0] s1_q;
    reg signed [19:0] s2_i;
    reg signed [19:0] s2_q;
    reg sub1;
    reg sub2;
    reg premod_phase;
    reg [2:0] ph1;
    reg [2:0] ph2;
    reg [2:0] phn;

    wire advance = ~OUT_VALID_O | OUT_READY_I;
    wire emit = busy & advance;
    wire last1 = first_stage_skip | sub1;
    wire last2 = second_stage_skip | sub2;

    // Q reads forced to zero while the Q path is frozen
    wire dup = i_channel_duplicate;
    wire signed [19:0] xq_r = dup ? 20'sh00000 : x_q;
    wire signed [19:0] x1pq_r = dup ? 20'sh00000 : x1p_q;
    wire signed [19:0] y2pq_r = dup ? 20'sh00000 : y2p_q;
    wire signed [19:0] s1q_r = dup ? 20'sh00000 : s1_q;
    wire signed [19:0] s2q_r = dup ? 20'sh00000 : s2_q;

    // loaded sample with optional fs/2 premodulation
    wire signed [19:0] ld_i = {{4{buf_i[buf_rptr][15]}}, buf_i[buf_rptr]};
    wire signed [19:0] ld_q = {{4{buf_q[buf_rptr][15]}}, buf_q[buf_rptr]};
    wire premod_neg = ~premod_skip & premod_phase;

    // ----------------------------------------
    // per-output datapath
    // ----------------------------------------
    // first stage: midpoint then x, shifted by mode quarter-rate steps
    wire signed [19:0] u1_i = last1 & ~first_stage_skip | first_stage_skip ? x_i :
        avg2(x1p_i, x_i);
    wire signed [19:0] u1_q = last1 & ~first_stage_skip | first_stage_skip ? xq_r :
        avg2(x1pq_r, xq_r);
    wire [2:0] ang1 = first_stage_skip ? 3'h0 : ph1;
    wire signed [19:0] y1_i = rot_sel(u1_i, u1_q, ang1, 1'b0);
    wire signed [19:0] y1_q = rot_sel(u1_i, u1_q, ang1, 1'b1);

    // second stage: same scheme with eighth-rate steps
    wire signed [19:0] u2_i = sub2 | second_stage_skip ? y1_i : avg2(y2p_i, y1_i);
    wire signed [19:0] u2_q = sub2 | second_stage_skip ? y1_q : avg2(y2pq_r, y1_q);
    wire [2:0] ang2 = second_stage_skip ? 3'h0 : ph2;
    wire signed [19:0] y2_i = rot_sel(u2_i, u2_q, ang2, 1'b0);
    wire signed [19:0] y2_q = rot_sel(u2_i, u2_q, ang2, 1'b1);

    // oscillator mix, conjugate carrier picks the low-side image
    wire [2:0] angn = sideband_low ? (3'h0 - phn) : phn;
    wire signed [19:0] m_i = rot_sel(y2_i, y2_q, angn, 1'b0);
    wire signed [19:0] m_q = rot_sel(y2_i, y2_q, angn, 1'b1);
    wire signed [19:0] z_i = oscillator_skip ? y2_i :
        (oscillator_half_gain ? (m_i >>> 1) : m_i);
    wire signed [19:0] z_q = oscillator_skip ? y2_q :
        (oscillator_half_gain ? (m_q >>> 1) : m_q);

    // phase skew and dc offset correction
    wire signed [27:0] skew = z_i * PHASE_COEF;
    wire signed [19:0] p_i = phase_skip ? z_i : z_i + DC_I;
    wire signed [19:0] p_q = phase_skip ? z_q : z_q + DC_Q + skew[27:8];

    // inverse sinc: 3-tap peaking, costs one sample of delay
    wire signed [19:0] v_i = sinc_skip ? p_i :
        s1_i + (s1_i >>> 3) - ((p_i + s2_i) >>> 4);
    wire signed [19:0] v_q = sinc_skip ? p_q :
        s1q_r + (s1q_r >>> 3) - ((p_q + s2q_r) >>> 4);

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // load takes a bubble cycle; kept simple over throughput
    always @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            busy <= 1'b0;
            x_i <= 20'sh00000;
            x_q <= 20'sh00000;
            x1p_i <= 20'sh00000;
            x1p_q <= 20'sh00000;
            y2p_i <= 20'sh00000;
            y2p_q <= 20'sh00000;
            s1_i <= 20'sh00000;
            s1_q <= 20'sh00000;
            s2_i <= 20'sh00000;
            s2_q <= 20'sh00000;
            sub1 <= 1'b0;
            sub2 <= 1'b0;
            premod_phase <= 1'b0;
            ph1 <= 3'h0;
            ph2 <= 3'h0;
            phn <= 3'h0;
        end
        else if (pop)
        begin
            busy <= 1'b1;
            x_i <= premod_neg ? -ld_i : ld_i;
            if (!dup)
                x_q <= premod_neg ? -ld_q : ld_q;
            if (!premod_skip)
                premod_phase <= ~premod_phase;
        end
        else if (emit)
        begin
            s2_i <= s1_i;
            s1_i <= p_i;
            if (!dup)
            begin
                s2_q <= s1_q;
                s1_q <= p_q;
            end
            if (!second_stage_skip)
                ph2 <= ph2 + second_halfband_mode[2:0];
            if (!oscillator_skip)
                phn <= phn + NCO_STEP;
            if (!last2)
                sub2 <= 1'b1;
            else
            begin
                sub2 <= 1'b0;
                y2p_i <= y1_i;
                if (!dup)
                    y2p_q <= y1_q;
                if (!first_stage_skip)
                    ph1 <= ph1 + {first_halfband_mode, 1'b0};
                if (!last1)
                    sub1 <= 1'b1;
                else
                begin
                    sub1 <= 1'b0;
                    busy <= 1'b0;
                    x1p_i <= x_i;
                    if (!dup)
                        x1p_q <= x_q;
                end
            end
        end
    end

    // ----------------------------------------
    // output register
    // ----------------------------------------
    always @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            OUT_I_O <= 16'h0000;
            OUT_Q_O <= 16'h0000;
            OUT_VALID_O <= 1'b0;
        end
        else if (advance)
        begin
            OUT_VALID_O <= emit;
            if (emit)
            begin
                OUT_I_O <= sat16(v_i);
                OUT_Q_O <= dup ? sat16(v_i) : sat16(v_q);
            end
        end
    end

endmodule // dpic_top

`default_nettype wire

// ==== tb/dpic_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dpic_defines.vh"

module dpic_chk (
    input wire CLK_SYS_I, // system clock
    input wire RST_N_I, // async reset, active low
    input wire [7:0] REG_ADDR_I, // register address
    input wire [7:0] REG_WDATA_I, // register write data
    input wire REG_WR_I, // write strobe
    input wire REG_RD_I, // read strobe
    input wire [7:0] REG_RDATA_O, // read data
    input wire IN_READY_O, // input buffer ready
    input wire [15:0] OUT_I_O, // I converter sample
    input wire [15:0] OUT_Q_O, // Q converter sample
    input wire OUT_VALID_O, // output valid
    input wire OUT_READY_I // converter takes sample
);
    reg [7:0] shadow_dp;
    reg [7:0] shadow_hb1;
    reg [7:0] shadow_hb2;

    // ----------------------------------------
    // shadow registers
    // ----------------------------------------
    // keeps what a read must return, so readback checks span write to read
    always @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            shadow_dp <= `DPIC_DATAPATH_RST;
            shadow_hb1 <= `DPIC_HB1_RST;
            shadow_hb2 <= `DPIC_HB2_RST;
        end
        else if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                `DPIC_ADDR_DATAPATH: shadow_dp <= REG_WDATA_I & `DPIC_DATAPATH_MASK;
                `DPIC_ADDR_HB1: shadow_hb1 <= REG_WDATA_I & `DPIC_HB1_MASK;
                `DPIC_ADDR_HB2: shadow_hb2 <= REG_WDATA_I & `DPIC_HB2_MASK;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    a_dp_readback: assert property (
        REG_RD_I && REG_ADDR_I == `DPIC_ADDR_DATAPATH |=> REG_RDATA_O == $past(shadow_dp))
        else $error("datapath control readback wrong");
    a_hb1_readback: assert property (
        REG_RD_I && REG_ADDR_I == `DPIC_ADDR_HB1 |=> REG_RDATA_O == $past(shadow_hb1))
        else $error("first stage control readback wrong");
    a_hb2_readback: assert property (
        REG_RD_I && REG_ADDR_I == `DPIC_ADDR_HB2 |=> REG_RDATA_O == $past(shadow_hb2))
        else $error("second stage control readback wrong");
    a_unmapped_zero: assert property (
        REG_RD_I && (REG_ADDR_I < 8'h1b || REG_ADDR_I > 8'h1d) |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data changed without a read");
    a_dup_copy: assert property (
        OUT_VALID_O && shadow_dp[`DPIC_BIT_DUPLICATE] |-> OUT_Q_O == OUT_I_O)
        else $error("Q output differs from I while duplicating");
    a_out_holds: assert property (
        OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_I_O) && $stable(OUT_Q_O))
        else $error("stalled output not held");
    a_ready_after_reset: assert property (
        $rose(RST_N_I) |-> ##1 IN_READY_O)
        else $error("input not ready after reset");

    // main scenarios reached
    c_unmapped: cover property (REG_RD_I && REG_ADDR_I == 8'h1f);
    c_stall: cover property (OUT_VALID_O && !OUT_READY_I);
    c_dup: cover property (OUT_VALID_O && shadow_dp[`DPIC_BIT_DUPLICATE]);
endmodule // dpic_chk

bind dpic_top dpic_chk dpic_chk_inst (
    .CLK_SYS_I(CLK_SYS_I),
    .RST_N_I(RST_N_I),
    .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O),
    .IN_READY_O(IN_READY_O),
    .OUT_I_O(OUT_I_O),
    .OUT_Q_O(OUT_Q_O),
    .OUT_VALID_O(OUT_VALID_O),
    .OUT_READY_I(OUT_READY_I)
);
`default_nettype wire

// ==== tb/tb_dac_datapath_interpolation_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dpic_defines.vh"

module tb_dac_datapath_interpolation_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] in_i = 16'h0000;
    logic [15:0] in_q = 16'h0000;
    logic in_valid = 1'b0;
    logic out_ready = 1'b0;
    logic cmp_on = 1'b0;
    wire [7:0] rdata;
    wire in_ready;
    wire [15:0] out_i;
    wire [15:0] out_q;
    wire out_valid;
    int errors = 0;
    int samples_checked = 0;
    int got = 0;
    logic [31:0] want;
    logic [31:0] exp_q[$];
    logic [31:0] cfg[4] = '{32'he4010102, 32'he4020104, 32'h4a074804, 32'h4a067e08};

    always #20 clk = ~clk;

    dpic_top dpic_top_inst (
        .CLK_SYS_I(clk),
        .RST_N_I(rst_n),
        .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata),
        .REG_WR_I(wr),
        .REG_RD_I(rd),
        .REG_RDATA_O(rdata),
        .IN_I_I(in_i),
        .IN_Q_I(in_q),
        .IN_VALID_I(in_valid),
        .IN_READY_O(in_ready),
        .OUT_I_O(out_i),
        .OUT_Q_O(out_q),
        .OUT_VALID_O(out_valid),
        .OUT_READY_I(out_ready)
    );

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // strobes span one rising edge, then drop; the leading wait avoids re-driving in one step
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check($sformatf("register %h", a), {24'h0, exp}, {24'h0, rdata});
    endtask

    // sample is held until the buffer shows ready, so a refusal loses nothing
    task automatic push(input logic [15:0] i, input logic [15:0] q);
        int n;
        n = 0;
        @(negedge clk);
        in_i = i;
        in_q = q;
        in_valid = 1'b1;
        while (in_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        check("input taken in time", 32'h1, {31'h0, n < 100});
        @(negedge clk);
        in_valid = 1'b0;
    endtask

    task automatic drain(input int want);
        int n;
        n = 0;
        while ((exp_q.size() > 0 || got < want) && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        repeat (8) @(negedge clk);
        // a silent engine must not leave expectations unchecked
        check("outputs still owed", 32'h0, exp_q.size());
    endtask

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // output collector
    // ----------------------------------------
    // looks a little after the falling edge so outputs and ready have settled
    always @(negedge clk)
    begin
        #1;
        if (out_valid === 1'b1 && out_ready === 1'b1)
        begin
            got++;
            if (cmp_on)
            begin
                want = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx;
                check("output pair", want, {out_i, out_q});
            end
        end
    end

    initial
    begin
        #(40 * 20000);
        errors++;
        report_and_stop();
    end

    initial
    begin
        int k;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        reg_read(`DPIC_ADDR_DATAPATH, 8'he4);
        reg_read(`DPIC_ADDR_HB1, 8'h00);
        reg_read(`DPIC_ADDR_HB2, 8'h00);
        reg_write(`DPIC_ADDR_DATAPATH, 8'hff);
        reg_read(`DPIC_ADDR_DATAPATH, 8'hef);
        reg_write(`DPIC_ADDR_HB1, 8'hff);
        reg_read(`DPIC_ADDR_HB1, 8'h07);
        reg_write(`DPIC_ADDR_HB2, 8'hff);
        reg_read(`DPIC_ADDR_HB2, 8'h7f);
        reg_write(8'h1f, 8'h5a);
        reg_read(8'h1f, 8'h00);
        // all four first-stage mode codes and eight second-stage codes (both halves equal) must stick
        for (int m = 0; m < 4; m++)
        begin
            reg_write(`DPIC_ADDR_HB1, 8'(m << 1));
            reg_read(`DPIC_ADDR_HB1, 8'(m << 1));
        end
        for (int m = 0; m < 8; m++)
        begin
            reg_write(`DPIC_ADDR_HB2, 8'({m[2:0], m[2:0], 1'b0}));
            reg_read(`DPIC_ADDR_HB2, 8'({m[2:0], m[2:0], 1'b0}));
        end
        // full bypass: fill against a stalled converter, then drain in order
        reg_write(`DPIC_ADDR_DATAPATH, 8'he4);
        reg_write(`DPIC_ADDR_HB1, 8'h01);
        reg_write(`DPIC_ADDR_HB2, 8'h01);
        cmp_on = 1'b1;
        @(negedge clk);
        k = 0;
        in_i = 16'h1234;
        in_q = 16'h8765;
        in_valid = 1'b1;
        while (in_ready === 1'b1 && k < 8)
        begin
            exp_q.push_back({in_i, in_q});
            k++;
            @(negedge clk);
            in_i = in_i + 16'h1111;
            in_q = in_q - 16'h0101;
        end
        in_valid = 1'b0;
        check("buffer refused", 32'h1, {31'h0, k >= 2 && k < 8});
        repeat (4) @(negedge clk);
        out_ready = 1'b1;
        drain(0);
        check("input ready after drain", 32'h1, {31'h0, in_ready});
        // Q input ignored, I sent to both converters
        reg_write(`DPIC_ADDR_DATAPATH, 8'he5);
        exp_q.push_back(32'h7fff7fff);
        exp_q.push_back(32'h80018001);
        push(16'h7fff, 16'h0f0f);
        push(16'h8001, 16'h2222);
        drain(0);
        // outputs per input follow the two stage bypass bits
        for (int c = 0; c < 4; c++)
        begin
            // configs 1 and 2 also compare values, from the state earlier runs leave
            cmp_on = (c == 1 || c == 2);
            if (c == 1)
                exp_q = '{32'h00000180, 32'hfe000400, 32'h0000fe80, 32'h01000400};
            else if (c == 2)
                exp_q = '{32'h01400180, 32'hff000200, 32'hfe00ffc0, 32'hff80fe00};
            reg_write(`DPIC_ADDR_DATAPATH, cfg[c][31:24]);
            reg_write(`DPIC_ADDR_HB1, cfg[c][23:16]);
            reg_write(`DPIC_ADDR_HB2, cfg[c][15:8]);
            got = 0;
            push(16'h0400, 16'h0200);
            push(16'hfc00, 16'h0100);
            drain(int'(cfg[c][7:0]));
            check("outputs per two inputs", {24'h0, cfg[c][7:0]}, got);
        end
        report_and_stop();
    end
endmodule // tb_dac_datapath_interpolation_control
`default_nettype wire
